// >>> hdl/pwm_cycle_config.v
// pwm cycle configuration, overflow flag, interrupt and compare/reload access
// Function
// - Reload-select 0 maps the compare high/low addresses to the compare registers, 1 to reload.
// - Reload registers give the compare reload value in 9, 10 and 11-bit pwm.
// - In any other mode the reload registers have no effect.
// - Interrupt is requested while the overflow flag and its enable are both set; irq also needs irq_mask_r and holds until irq_status_r is cleared.
// - The flag sets when the main counter overflows out of bit 7, 8, 9 or 10.
// - The cycle-length select picks which counter bit drives the flag.
// - Software may set the flag by writing 1; only software clears it by writing 0.
// - Configuration bits 4 to 2 read zero and ignore writes.
// - Length code 00..11 gives 8, 9, 10, 11-bit cycles.
// - The selected length applies to every non-16-bit pwm channel.
// - A 16-bit pwm channel ignores the length select.
// - The configuration register resets to all zero.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_cycle_regs.vh"
module pwm_cycle_config
#(
    parameter CHANNELS = 3
)
(
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [15:0] main_counter,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [1:0] cycle_length_r,
    output reg [16*CHANNELS-1:0] compare_value_pair_r,
    output reg irq
);
    reg reload_register_select_r;
    reg cycle_overflow_irq_enable_r;
    reg cycle_overflow_flag_r;
    reg [1:0] cycle_length_select_r;
    reg [2*CHANNELS-1:0] mode_r;
    reg [1:0] chan_r;
    reg irq_status_r;
    reg irq_mask_r;
    reg [7:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg aw_have_r;
    reg w_have_r;
    wire do_write;
    wire wr_cfg;
    wire wr_high;
    wire wr_low;
    wire overflow_pulse;
    wire reload_pulse;
    wire [7:0] rd_high;
    wire [7:0] rd_low;
    wire [16*CHANNELS-1:0] compare_value_pair;
    wire [7:0] cfg_view;
    wire sw_flag_set;
    wire sw_flag_clear;
    wire ovf_irq_out;

    // true when the byte address hits a mapped register
    function mapped;
        input [7:0] a;
        begin
            if (a == `CFG_OFFSET)
                mapped = 1'b1;
            else if (a == `CMP_HIGH_OFFSET)
                mapped = 1'b1;
            else if (a == `CMP_LOW_OFFSET)
                mapped = 1'b1;
            else if (a == `MODE_OFFSET)
                mapped = 1'b1;
            else if (a == `IRQ_STATUS_OFFSET)
                mapped = 1'b1;
            else if (a == `IRQ_MASK_OFFSET)
                mapped = 1'b1;
            else if (a == `CHAN_SEL_OFFSET)
                mapped = 1'b1;
            else
                mapped = 1'b0;
        end
    endfunction

    cycle_overflow_detect i_cycle_overflow_detect
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .main_counter(main_counter),
        .cycle_length_select(cycle_length_select_r),
        .overflow_pulse(overflow_pulse)
    );

    compare_bank #(.CHANNELS(CHANNELS)) i_compare_bank
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .chan(chan_r),
        .reload_register_select(reload_register_select_r),
        .wr_high(wr_high),
        .wr_low(wr_low),
        .wdata(wdata_r[7:0]),
        .mode(mode_r),
        .overflow_pulse(reload_pulse),
        .rd_high(rd_high),
        .rd_low(rd_low),
        .compare_value_pair(compare_value_pair)
    );

    // write fires once both address and data are held; byte lane 0 carries the data
    assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid & ce;
    assign wr_cfg = do_write & (awaddr_r == `CFG_OFFSET) & wstrb_r[0];
    assign wr_high = do_write & (awaddr_r == `CMP_HIGH_OFFSET) & wstrb_r[0];
    assign wr_low = do_write & (awaddr_r == `CMP_LOW_OFFSET) & wstrb_r[0];
    assign sw_flag_set = wr_cfg & wdata_r[`CFG_OVF_FLAG_BIT];
    assign sw_flag_clear = wr_cfg & ~wdata_r[`CFG_OVF_FLAG_BIT];

    // unused bits 4:2 are forced to zero on read
    assign cfg_view = {reload_register_select_r, cycle_overflow_irq_enable_r,
        cycle_overflow_flag_r, 3'h0, cycle_length_select_r};

    assign ovf_irq_out = cycle_overflow_flag_r & cycle_overflow_irq_enable_r;

    // 8-bit cycles never reload; the flag itself still sets at every length
    assign reload_pulse = overflow_pulse & (cycle_length_select_r != 2'h0);

    // write channels: accept each independently, answer after both
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end
        else if (ce)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_have_r && !s_axi_awready)
            begin
                s_axi_awready <= 1'b1;
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_r && !s_axi_wready)
            begin
                s_axi_wready <= 1'b1;
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    // read channel: one read at a time, answer one cycle after the address
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (s_axi_araddr == `CFG_OFFSET)
                    s_axi_rdata <= {24'h000000, cfg_view};
                else if (s_axi_araddr == `CMP_HIGH_OFFSET)
                    s_axi_rdata <= {24'h000000, rd_high};
                else if (s_axi_araddr == `CMP_LOW_OFFSET)
                    s_axi_rdata <= {24'h000000, rd_low};
                else if (s_axi_araddr == `MODE_OFFSET)
                    s_axi_rdata <= {{(32-2*CHANNELS){1'b0}}, mode_r};
                else if (s_axi_araddr == `IRQ_STATUS_OFFSET)
                    s_axi_rdata <= {31'h00000000, irq_status_r};
                else if (s_axi_araddr == `IRQ_MASK_OFFSET)
                    s_axi_rdata <= {31'h00000000, irq_mask_r};
                else if (s_axi_araddr == `CHAN_SEL_OFFSET)
                    s_axi_rdata <= {30'h00000000, chan_r};
                else
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // configuration register and the sticky cycle overflow flag
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reload_register_select_r <= 1'b0;
            cycle_overflow_irq_enable_r <= 1'b0;
            cycle_overflow_flag_r <= 1'b0;
            cycle_length_select_r <= 2'h0;
        end
        else if (ce)
        begin
            if (wr_cfg)
            begin
                reload_register_select_r <= wdata_r[`CFG_RELOAD_SEL_BIT];
                cycle_overflow_irq_enable_r <= wdata_r[`CFG_OVF_IRQ_EN_BIT];
                cycle_length_select_r <= wdata_r[`CFG_LEN_SEL_MSB:`CFG_LEN_SEL_LSB];
            end
            // hardware set beats a same-cycle software clear
            if (overflow_pulse || sw_flag_set)
                cycle_overflow_flag_r <= 1'b1;
            else if (sw_flag_clear)
                cycle_overflow_flag_r <= 1'b0;
        end
    end

    // mode, channel select, interrupt status (write one to clear) and mask
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_r <= {(2*CHANNELS){1'b0}};
            chan_r <= 2'h0;
            irq_status_r <= 1'b0;
            irq_mask_r <= 1'b0;
        end
        else if (ce)
        begin
            if (do_write && awaddr_r == `MODE_OFFSET && wstrb_r[0])
                mode_r <= wdata_r[2*CHANNELS-1:0];
            if (do_write && awaddr_r == `CHAN_SEL_OFFSET && wstrb_r[0])
                chan_r <= wdata_r[1:0];
            if (do_write && awaddr_r == `IRQ_MASK_OFFSET && wstrb_r[0])
                irq_mask_r <= wdata_r[`IRQ_OVF_BIT];
            // event wins over a write-one clear in the same cycle
            if (ovf_irq_out)
                irq_status_r <= 1'b1;
            else if (do_write && awaddr_r == `IRQ_STATUS_OFFSET && wstrb_r[0]
                && wdata_r[`IRQ_OVF_BIT])
                irq_status_r <= 1'b0;
        end
    end

    // registered outputs, so every port leaves from a flip-flop; irq lags status by a cycle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq <= 1'b0;
            cycle_length_r <= 2'h0;
            compare_value_pair_r <= {(16*CHANNELS){1'b0}};
        end
        else if (ce)
        begin
            irq <= irq_status_r & irq_mask_r;
            cycle_length_r <= cycle_length_select_r;
            compare_value_pair_r <= compare_value_pair;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/pwm_cycle_regs.vh
// register offsets, field positions and reset values of the pwm cycle configuration block
`ifndef PWM_CYCLE_REGS_VH
`define PWM_CYCLE_REGS_VH
// byte addresses on the register bus
`define CFG_OFFSET 8'h00
`define CMP_HIGH_OFFSET 8'h04
`define CMP_LOW_OFFSET 8'h08
`define MODE_OFFSET 8'h0c
`define IRQ_STATUS_OFFSET 8'h10
`define IRQ_MASK_OFFSET 8'h14
`define CHAN_SEL_OFFSET 8'h18
// printed address of the configuration register, kept for reference
`define CFG_PRINTED_ADDR 8'ha1
// configuration fields
`define CFG_RELOAD_SEL_BIT 7
`define CFG_OVF_IRQ_EN_BIT 6
`define CFG_OVF_FLAG_BIT 5
`define CFG_LEN_SEL_LSB 0
`define CFG_LEN_SEL_MSB 1
`define CFG_RESET 8'h00
// mode register fields: bit0 pwm enable, bit1 16-bit pwm
`define MODE_PWM_BIT 0
`define MODE_PWM16_BIT 1
`define MODE_RESET 2'h0
// interrupt status bit of the cycle overflow event
`define IRQ_OVF_BIT 0
// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hdl/cycle_overflow_detect.v
// picks the counter bit whose carry marks the end of a pwm cycle
`timescale 1ns/100ps
`default_nettype none
module cycle_overflow_detect
(
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [15:0] main_counter,
    input wire [1:0] cycle_length_select,
    output wire overflow_pulse
);
    reg prev_bit_r;
    wire sel_bit;

    // 00 selects bit 7 (8 bits) up to 11 selecting bit 10 (11 bits)
    assign sel_bit = main_counter[{2'h0, cycle_length_select} + 4'h7];

    // remember last value of the selected bit to find its falling edge
    always @(posedge aclk)
    begin
        if (!aresetn)
            prev_bit_r <= 1'b0;
        else if (ce)
            prev_bit_r <= sel_bit;
    end

    // overflow out of the selected bit is its 1 to 0 transition
    assign overflow_pulse = ce & prev_bit_r & ~sel_bit;
endmodule
`default_nettype wire

// >>> hdl/compare_bank.v
// per-channel compare and auto-reload storage with the reload-at-cycle-end behaviour
`timescale 1ns/100ps
`default_nettype none
module compare_bank
#(
    parameter CHANNELS = 3
)
(
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [1:0] chan,
    input wire reload_register_select,
    input wire wr_high,
    input wire wr_low,
    input wire [7:0] wdata,
    input wire [2*CHANNELS-1:0] mode,
    input wire overflow_pulse,
    output reg [7:0] rd_high,
    output reg [7:0] rd_low,
    output wire [16*CHANNELS-1:0] compare_value_pair
);
    reg [15:0] cmp_r [0:CHANNELS-1];
    reg [15:0] reload_r [0:CHANNELS-1];
    integer i;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1)
        begin : g_out
            assign compare_value_pair[16*g+15:16*g] = cmp_r[g];
        end
    endgenerate

    // software access goes to compare or reload storage by the select bit
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (i = 0; i < CHANNELS; i = i + 1)
            begin
                cmp_r[i] <= 16'h0000;
                reload_r[i] <= 16'h0000;
            end
        end
        else if (ce)
        begin
            for (i = 0; i < CHANNELS; i = i + 1)
            begin
                // reload only in 9..11-bit pwm; 16-bit and other modes ignore it
                if (overflow_pulse && mode[2*i] && !mode[2*i+1])
                    cmp_r[i] <= reload_r[i];
                if (chan == i[1:0])
                begin
                    if (reload_register_select)
                    begin
                        if (wr_high)
                            reload_r[i][15:8] <= wdata;
                        if (wr_low)
                            reload_r[i][7:0] <= wdata;
                    end
                    else
                    begin
                        if (wr_high)
                            cmp_r[i][15:8] <= wdata;
                        if (wr_low)
                            cmp_r[i][7:0] <= wdata;
                    end
                end
            end
        end
    end

    // read mux; unknown channel reads zero
    always @*
    begin
        rd_high = 8'h00;
        rd_low = 8'h00;
        for (i = 0; i < CHANNELS; i = i + 1)
        begin
            if (chan == i[1:0])
            begin
                rd_high = reload_register_select ? reload_r[i][15:8] : cmp_r[i][15:8];
                rd_low = reload_register_select ? reload_r[i][7:0] : cmp_r[i][7:0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/pwm_cycle_config_sva.sv
// port-level assertions of the pwm cycle configuration block
`timescale 1ns/100ps
`default_nettype none
`include "pwm_cycle_regs.vh"
module pwm_cycle_config_sva
#(
    parameter CHANNELS = 3
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] main_counter,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] cycle_length_r,
    input wire logic [16*CHANNELS-1:0] compare_value_pair_r,
    input wire logic irq
);
    logic [7:0] aw_a_r;
    logic [7:0] w_d_r;
    logic mask_r;
    logic rsel_r;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // shadows follow the write handshake edge, one edge after the design takes the write data
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_a_r <= 8'h00;
            w_d_r <= 8'h00;
            mask_r <= 1'b0;
            rsel_r <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            aw_a_r <= s_axi_awaddr;
            w_d_r <= s_axi_wdata[7:0];
            if (s_axi_awaddr == `IRQ_MASK_OFFSET)
                mask_r <= s_axi_wdata[0];
            if (s_axi_awaddr == `CFG_OFFSET)
                rsel_r <= s_axi_wdata[7];
        end
    end
    a_reset_clear: assert property (
        $rose(aresetn) |-> cycle_length_r == 2'h0 && !irq && compare_value_pair_r == '0)
        else $error("outputs not clear after reset");
    a_len_lands: assert property (
        $rose(s_axi_bvalid) && aw_a_r == `CFG_OFFSET |-> ##1 cycle_length_r == w_d_r[1:0])
        else $error("length code differs from written value");
    a_len_only_write: assert property (
        $changed(cycle_length_r) |-> $past(s_axi_bvalid) && aw_a_r == `CFG_OFFSET)
        else $error("length code moved without a write");
    a_cfg_zero_bits: assert property (
        $rose(s_axi_rvalid) && s_axi_araddr == `CFG_OFFSET
        |-> s_axi_rdata[4:2] == 3'h0 && s_axi_rdata[31:8] == 24'h0)
        else $error("unused configuration bits read nonzero");
    // a counter that sat still for three cycles cannot have caused a reload
    a_reload_hidden: assert property (
        $rose(s_axi_bvalid) && rsel_r
        && (aw_a_r == `CMP_HIGH_OFFSET || aw_a_r == `CMP_LOW_OFFSET)
        && main_counter == $past(main_counter, 3) |-> ##1 $stable(compare_value_pair_r))
        else $error("reload write reached compare registers");
    a_no_reload_8bit: assert property (
        $changed(compare_value_pair_r) && !$past(s_axi_bvalid) |-> cycle_length_r != 2'h0)
        else $error("reload applied in 8-bit cycles");
    a_irq_masked: assert property (
        $rose(irq) |-> mask_r || $past(mask_r))
        else $error("interrupt rose while masked");
    a_read_answer: assert property (
        s_axi_arvalid && !s_axi_rvalid |-> ##[1:4] s_axi_rvalid)
        else $error("read not answered");
    c_irq: cover property ($rose(irq));
    c_reload: cover property ($changed(compare_value_pair_r) && !$past(s_axi_bvalid));
    c_cfg_read: cover property ($rose(s_axi_rvalid) && s_axi_araddr == `CFG_OFFSET);
endmodule
`default_nettype wire

// >>> verification/tb_pwm_cycle_config.sv
// self-checking testbench of the pwm cycle configuration block
`timescale 1ns/100ps
`default_nettype none
`include "pwm_cycle_regs.vh"
module tb_pwm_cycle_config;
    localparam CHANNELS = 3;
    logic aclk = 0;
    logic aresetn = 0;
    logic ce = 1;
    logic [15:0] main_counter = 16'h0000;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, len;
    logic [31:0] rdata, rd_d;
    logic [16*CHANNELS-1:0] cmp;
    logic [1:0] rsp;
    int num_errors = 0, num_checks = 0, cycles = 0, c;
    pwm_cycle_config #(.CHANNELS(CHANNELS)) i_pwm_cycle_config (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .main_counter(main_counter),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cycle_length_r(len),
        .compare_value_pair_r(cmp), .irq(irq));
    // clock and a hang guard far beyond the few hundred cycles needed
    always #10 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            $display("MISMATCH at %0t: timeout", $time);
            close_out;
        end
    end
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [47:0] got, input logic [47:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // address and data offered together, bready held until the response
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic done;
        done = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 0;
            if (wready)
                wvalid <= 0;
            if (bvalid)
            begin
                rsp = bresp;
                bready <= 0;
                done = 1;
            end
        end
        chk(done, 1, "write answer");
    endtask
    task rd(input logic [7:0] a);
        logic done;
        done = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 0;
            if (rvalid)
            begin
                rd_d = rdata;
                rsp = rresp;
                rready <= 0;
                done = 1;
            end
        end
        chk(done, 1, "read answer");
    endtask
    task rc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk({rsp, rd_d}, {2'b00, 24'h0, exp}, "read value");
    endtask
    // one-cycle high on a counter bit, then its fall
    task ovf(input int b);
        @(posedge aclk);
        main_counter <= 16'h0001 << b;
        @(posedge aclk);
        main_counter <= 16'h0000;
        repeat (4) @(posedge aclk);
    endtask
    task t_reset;
        rc(`CFG_OFFSET, 8'h00);
        chk({len, irq}, 0, "reset length and irq");
        chk(cmp, 0, "reset compare");
        $display("test reset done");
    endtask
    task t_cfg;
        for (c = 0; c < 4; c++)
        begin
            wr(`CFG_OFFSET, 8'h1c | c);
            @(posedge aclk);
            chk(len, c, "length code");
            rc(`CFG_OFFSET, c);
        end
        wr(`CFG_OFFSET, 8'h20);
        rc(`CFG_OFFSET, 8'h20);
        wr(`CFG_OFFSET, 8'h00);
        rc(`CFG_OFFSET, 8'h00);
        $display("test configuration done");
    endtask
    // the next higher bit must not count; the selected bit must
    task t_ovf;
        for (c = 0; c < 4; c++)
        begin
            wr(`CFG_OFFSET, c);
            ovf(8 + c);
            rc(`CFG_OFFSET, c);
            ovf(7 + c);
            repeat (20) @(posedge aclk);
            rc(`CFG_OFFSET, 8'h20 | c);
        end
        wr(`CFG_OFFSET, 8'h00);
        $display("test overflow done");
    endtask
    task t_irq;
        wr(`IRQ_MASK_OFFSET, 8'h01);
        ovf(7);
        rc(`IRQ_STATUS_OFFSET, 8'h00);
        chk(irq, 0, "irq disabled");
        wr(`CFG_OFFSET, 8'h60);
        rc(`IRQ_STATUS_OFFSET, 8'h01);
        chk(irq, 1, "irq raised");
        wr(`IRQ_MASK_OFFSET, 8'h00);
        repeat (2) @(posedge aclk);
        chk(irq, 0, "irq masked");
        wr(`CFG_OFFSET, 8'h00);
        wr(`IRQ_STATUS_OFFSET, 8'h01);
        wr(`IRQ_MASK_OFFSET, 8'h01);
        rc(`IRQ_STATUS_OFFSET, 8'h00);
        chk(irq, 0, "irq cleared");
        $display("test interrupt done");
    endtask
    // ch0 and ch2 in pwm, ch1 in 16-bit pwm
    task t_reload;
        for (c = 0; c < 3; c++)
        begin
            wr(`CHAN_SEL_OFFSET, c);
            wr(`CMP_HIGH_OFFSET, 8'h10 + c);
            wr(`CMP_LOW_OFFSET, 8'h20 + c);
        end
        wr(`CFG_OFFSET, 8'h80);
        for (c = 0; c < 3; c++)
        begin
            wr(`CHAN_SEL_OFFSET, c);
            wr(`CMP_HIGH_OFFSET, 8'h50 + c);
            wr(`CMP_LOW_OFFSET, 8'h60 + c);
            rc(`CMP_LOW_OFFSET, 8'h60 + c);
        end
        chk(cmp, 48'h1222_1121_1020, "compare kept");
        wr(`MODE_OFFSET, 8'h1d);
        ovf(7);
        chk(cmp, 48'h1222_1121_1020, "8-bit reload");
        wr(`CFG_OFFSET, 8'h81);
        ovf(8);
        chk(cmp, 48'h5262_1121_5060, "9-bit reload");
        wr(`CFG_OFFSET, 8'h01);
        rc(`CMP_HIGH_OFFSET, 8'h52);
        $display("test reload done");
    endtask
    // a frozen clock enable must hide an overflow; a mid-run reset clears all again
    task t_hold;
        wr(`CFG_OFFSET, 8'h83);
        @(posedge aclk);
        ce <= 0;
        ovf(10);
        @(posedge aclk);
        ce <= 1;
        rc(`CFG_OFFSET, 8'h83);
        chk(cmp, 48'h5262_1121_5060, "frozen reload");
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rc(`CFG_OFFSET, 8'h00);
        chk({len, irq}, 0, "length and irq after reset");
        chk(cmp, 0, "compare after reset");
        $display("test hold and reset done");
    endtask
    task t_bad;
        wr(8'h40, 8'hff);
        chk(rsp, `RESP_SLVERR, "unmapped write");
        rd(8'h40);
        chk({rsp, rd_d}, {`RESP_SLVERR, 32'h0}, "unmapped read");
        $display("test unmapped done");
    endtask
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        t_reset;
        t_cfg;
        t_ovf;
        t_irq;
        t_reload;
        t_hold;
        t_bad;
        close_out;
    end
endmodule
bind pwm_cycle_config pwm_cycle_config_sva #(.CHANNELS(CHANNELS)) i_pwm_cycle_config_sva (
    .aclk(aclk), .aresetn(aresetn), .main_counter(main_counter),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .cycle_length_r(cycle_length_r), .compare_value_pair_r(compare_value_pair_r), .irq(irq));
`default_nettype wire
